// *** logic/ebc_params.svh ***
// What this block does
// - Release bit resets 0; pins become ports
// - Release bit 1 allows request/grant handoff
// - Request-out enable resets 0; drives request
// - Request-out enable 0 leaves pin as port
// - Idle length bit: 0 one, 1 two
// - Idle between reads to different areas
// - Idle between read then write
// - Idle between write then read
// - Write buffer enable for external writes and DMA single transfers
// - Stall pin enable honours wait input
// - Reserved bits reset 0, stay read/write
`ifndef EBC_PARAMS_SVH
`define EBC_PARAMS_SVH
`define EBC_CTRL_REG_ADDR  12'h000
`define EBC_CTRL_REG_RESET 16'h1C00
`define EBC_BIT_RELEASE   15
`define EBC_BIT_REQ_OE    14
`define EBC_BIT_IDLE_LEN  12
`define EBC_BIT_AREA      11
`define EBC_BIT_RW        10
`define EBC_BIT_WBUF      9
`define EBC_BIT_STALL     8
`define EBC_BIT_WR        2
`endif

// *** logic/ebc_pkg.sv ***
package ebc_pkg;
   typedef enum logic [1:0] {
      EBC_BUS_OWN  = 2'b00,
      EBC_BUS_REL  = 2'b01
   } ebc_bus_e;
   typedef enum logic [1:0] {
      EBC_CYC_IDLE = 2'b00,
      EBC_CYC_GAP  = 2'b01,
      EBC_CYC_RUN  = 2'b10
   } ebc_cyc_e;
endpackage

// *** logic/ebc_arbiter.sv ***
`timescale 1ns/1ns
`include "ebc_params.svh"
module ebc_arbiter (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // Control
   input  wire logic release_en,
   input  wire logic req_out_en,
   input  wire logic int_need,
   input  wire logic refresh_req,
   input  wire logic cyc_busy,
   // Pins, active low; released is an active-high status
   input  wire logic bus_request_in_n,
   output logic      bus_grant_n,
   output logic      bus_request_out_n,
   output logic      released
);
   import ebc_pkg::*;
   ebc_bus_e st_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_q <= EBC_BUS_OWN;
      end else begin
         case (st_q)
            EBC_BUS_OWN: begin
               // Release only between cycles so no access is cut short.
               if (release_en && !bus_request_in_n && !cyc_busy) begin
                  st_q <= EBC_BUS_REL;
               end
            end
            EBC_BUS_REL: begin
               if (bus_request_in_n || !release_en) begin
                  st_q <= EBC_BUS_OWN;
               end
            end
            default: st_q <= EBC_BUS_OWN;
         endcase
      end
   end
   assign released = (st_q == EBC_BUS_REL);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bus_grant_n       <= 1'b1;
         bus_request_out_n <= 1'b1;
      end else begin
         bus_grant_n       <= ~(released && release_en);
         bus_request_out_n <= ~(released && req_out_en
                                && (int_need || refresh_req));
      end
   end
endmodule

// *** logic/ebc_idle_gen.sv ***
`timescale 1ns/1ns
`include "ebc_params.svh"
module ebc_idle_gen (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // Settings
   input  wire logic two_states,
   input  wire logic ins_area,
   input  wire logic ins_rw,
   input  wire logic ins_wr,
   // Cycle tracking
   input  wire logic start,
   input  wire logic start_wr,
   input  wire logic [2:0] start_area,
   input  wire logic done,
   output logic      gap_needed,
   output logic [1:0] gap_len
);
   logic       last_valid_q;
   logic       last_wr_q;
   logic [2:0] last_area_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         last_valid_q <= 1'b0;
         last_wr_q    <= 1'b0;
         last_area_q  <= 3'h0;
      end else if (start) begin
         last_valid_q <= 1'b1;
         last_wr_q    <= start_wr;
         last_area_q  <= start_area;
      end
   end
   always_comb begin
      gap_needed = 1'b0;
      if (last_valid_q && start) begin
         if (!last_wr_q && !start_wr && ins_area
             && last_area_q != start_area) begin
            gap_needed = 1'b1;
         end else if (!last_wr_q && start_wr && ins_rw) begin
            gap_needed = 1'b1;
         end else if (last_wr_q && !start_wr && ins_wr) begin
            gap_needed = 1'b1;
         end
      end
   end
   assign gap_len = two_states ? 2'h2 : 2'h1;
endmodule

// *** logic/ebc_ctrl.sv ***
`timescale 1ns/1ns
`include "ebc_params.svh"
module ebc_ctrl (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Internal access request
   input  wire logic        acc_req,
   input  wire logic        acc_wr,
   input  wire logic [2:0]  acc_area,
   input  wire logic        acc_dma_single,
   input  wire logic        refresh_req,
   output logic             acc_ack,
   // External cycle pins
   output logic             ext_rd_n,
   output logic             ext_wr_n,
   output logic             wdata_buffered,
   input  wire logic        stall_in_n,
   // Bus release pins
   input  wire logic        bus_request_in_n,
   output logic             bus_grant_n,
   output logic             bus_request_out_n,
   // Pins returned to port use
   output logic             release_pins_are_port,
   output logic             req_out_pin_is_port,
   output logic             stall_pin_is_port
);
   import ebc_pkg::*;
   ////////////////////////////////////////////////////////////////////
   logic [15:0] bus_control_reg_q;
   logic        hit;
   logic        wr_en;
   assign hit   = (paddr == `EBC_CTRL_REG_ADDR);
   assign wr_en = psel && penable && pwrite && hit;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !hit;
   // Reserved bits keep what is written so software can read them back.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bus_control_reg_q <= `EBC_CTRL_REG_RESET;
      end else if (wr_en) begin
         bus_control_reg_q <= pwdata[15:0];
      end
   end
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= hit ? {16'h0000, bus_control_reg_q} : 32'h0000_0000;
      end
   end
   logic ext_release_enable;
   logic bus_request_out_enable;
   logic idle_state_count_select;
   logic idle_insert_area_change;
   logic idle_insert_read_write;
   logic idle_insert_write_read;
   logic write_buffer_enable;
   logic stall_input_enable;
   assign ext_release_enable      = bus_control_reg_q[`EBC_BIT_RELEASE];
   assign bus_request_out_enable  = bus_control_reg_q[`EBC_BIT_REQ_OE];
   assign idle_state_count_select = bus_control_reg_q[`EBC_BIT_IDLE_LEN];
   assign idle_insert_area_change = bus_control_reg_q[`EBC_BIT_AREA];
   assign idle_insert_read_write  = bus_control_reg_q[`EBC_BIT_RW];
   assign idle_insert_write_read  = bus_control_reg_q[`EBC_BIT_WR];
   assign write_buffer_enable     = bus_control_reg_q[`EBC_BIT_WBUF];
   assign stall_input_enable      = bus_control_reg_q[`EBC_BIT_STALL];
   assign release_pins_are_port = !ext_release_enable;
   assign req_out_pin_is_port   = !bus_request_out_enable;
   assign stall_pin_is_port     = !stall_input_enable;
   ////////////////////////////////////////////////////////////////////
   ebc_cyc_e   cyc_q;
   logic [1:0] gap_cnt_q;
   logic       cur_wr_q;
   logic       released;
   logic       start;
   logic       gap_needed;
   logic [1:0] gap_len;
   logic       stall;
   ebc_arbiter u_arb (
      .core_clk          (core_clk),
      .sys_rst           (sys_rst),
      .release_en        (ext_release_enable),
      .req_out_en        (bus_request_out_enable),
      .int_need          (acc_req),
      .refresh_req       (refresh_req),
      // A cycle starting at this edge also blocks the hand-over.
      .cyc_busy          ((cyc_q != EBC_CYC_IDLE) || start),
      .bus_request_in_n  (bus_request_in_n),
      .bus_grant_n       (bus_grant_n),
      .bus_request_out_n (bus_request_out_n),
      .released          (released)
   );
   assign start = (cyc_q == EBC_CYC_IDLE) && acc_req && !released;
   ebc_idle_gen u_idle (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .two_states (idle_state_count_select),
      .ins_area   (idle_insert_area_change),
      .ins_rw     (idle_insert_read_write),
      .ins_wr     (idle_insert_write_read),
      .start      (start),
      .start_wr   (acc_wr),
      .start_area (acc_area),
      .done       (acc_ack),
      .gap_needed (gap_needed),
      .gap_len    (gap_len)
   );
   // The pin is only looked at while enabled, else it is a free port.
   assign stall = stall_input_enable && !stall_in_n;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cyc_q     <= EBC_CYC_IDLE;
         gap_cnt_q <= 2'h0;
         cur_wr_q  <= 1'b0;
      end else begin
         case (cyc_q)
            EBC_CYC_IDLE: begin
               if (start) begin
                  cur_wr_q <= acc_wr;
                  if (gap_needed) begin
                     cyc_q     <= EBC_CYC_GAP;
                     gap_cnt_q <= gap_len;
                  end else begin
                     cyc_q <= EBC_CYC_RUN;
                  end
               end
            end
            EBC_CYC_GAP: begin
               if (gap_cnt_q == 2'h1) begin
                  cyc_q <= EBC_CYC_RUN;
               end
               gap_cnt_q <= gap_cnt_q - 2'h1;
            end
            EBC_CYC_RUN: begin
               if (!stall) begin
                  cyc_q <= EBC_CYC_IDLE;
               end
            end
            default: cyc_q <= EBC_CYC_IDLE;
         endcase
      end
   end
   assign acc_ack = (cyc_q == EBC_CYC_RUN) && !stall;
   // Strobes are launched on the edge that enters the run state, so the
   // memory sees them while the cycle lasts and can stretch it.
   logic run_d;
   logic run_wr_d;
   always_comb begin
      run_d    = 1'b0;
      run_wr_d = cur_wr_q;
      case (cyc_q)
         EBC_CYC_IDLE: begin
            run_d    = start && !gap_needed;
            run_wr_d = acc_wr;
         end
         EBC_CYC_GAP: begin
            run_d = (gap_cnt_q == 2'h1);
         end
         EBC_CYC_RUN: begin
            run_d = stall;
         end
         default: begin
            run_d = 1'b0;
         end
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ext_rd_n       <= 1'b1;
         ext_wr_n       <= 1'b1;
         wdata_buffered <= 1'b0;
      end else begin
         // No strobe while idling between cycles or while released.
         ext_rd_n <= !(run_d && !run_wr_d);
         ext_wr_n <= !(run_d && run_wr_d);
         wdata_buffered <= write_buffer_enable && start
                           && (acc_wr || acc_dma_single);
      end
   end
endmodule

// *** dv/ebc_far_model.sv ***
`timescale 1ns/1ns
module ebc_far_model (
   // Bench controls
   input  wire logic core_clk,
   input  wire logic want_bus,
   input  wire logic stall_on,
   // Pins
   input  wire logic ext_rd_n,
   input  wire logic ext_wr_n,
   output logic      bus_request_in_n,
   output logic      stall_in_n
);
   logic [3:0] low_q = 4'h0;
   initial bus_request_in_n = 1'h1;
   always @(posedge core_clk)
      bus_request_in_n <= !want_bus;
   always @(posedge core_clk)
      low_q <= (ext_rd_n && ext_wr_n) ? 4'h0 : low_q + 4'h1;
   // A slow memory holds the first two strobe states; the pin has a pull-up.
   assign stall_in_n = !(stall_on && !(ext_rd_n && ext_wr_n)
                         && low_q < 4'h2);
endmodule

// *** dv/ebc_ctrl_checker.sv ***
`timescale 1ns/1ns
module ebc_ctrl_checker (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Watched pins
   input wire logic ext_rd_n,
   input wire logic ext_wr_n,
   input wire logic wdata_buffered,
   input wire logic bus_request_in_n,
   input wire logic bus_grant_n,
   input wire logic bus_request_out_n,
   input wire logic release_pins_are_port,
   input wire logic req_out_pin_is_port
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence s_strobe;
      ##[0:8] !(ext_rd_n && ext_wr_n);
   endsequence
   a_grant_off: assert property (release_pins_are_port |-> bus_grant_n)
      else $error("grant while off");
   a_req_off: assert property (
      release_pins_are_port |-> bus_request_out_n)
      else $error("request while off");
   a_grant_hold: assert property (
      !bus_grant_n && !bus_request_in_n |=> !bus_grant_n)
      else $error("grant dropped");
   a_grant_quiet: assert property (
      !bus_grant_n |-> ext_rd_n && ext_wr_n)
      else $error("strobe while released");
   a_req_rel: assert property (
      !bus_request_out_n |-> !bus_grant_n || !$past(bus_grant_n))
      else $error("request out while owned");
   a_req_en: assert property (
      req_out_pin_is_port && $past(req_out_pin_is_port)
      |-> bus_request_out_n) else $error("request out disabled");
   a_strobe_excl: assert property (ext_rd_n || ext_wr_n)
      else $error("both strobes low");
   a_buf_strobe: assert property (wdata_buffered |-> s_strobe)
      else $error("buffer with no cycle");
endmodule
//////////////////////////////
bind ebc_ctrl ebc_ctrl_checker chk (.core_clk, .sys_rst, .ext_rd_n,
   .ext_wr_n, .wdata_buffered, .bus_request_in_n, .bus_grant_n,
   .bus_request_out_n, .release_pins_are_port, .req_out_pin_is_port);

// *** dv/ebc_ctrl_tb.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
   checks++; \
   if ((g) !== (e)) begin \
      err_total++; \
      $display("Error %s exp %h got %h", nm, e, g); \
   end \
end
module ebc_ctrl_tb;
   logic        core_clk = 1'h0, sys_rst = 1'h1, e, psel = 1'h0;
   logic        penable = 1'h0, pwrite = 1'h0, acc_req = 1'h0, acc_wr = 1'h0;
   logic        acc_dma_single = 1'h0, refresh_req = 1'h0, want_bus = 1'h0;
   logic        stall_on = 1'h0, pready, pslverr, acc_ack, ext_rd_n;
   logic        ext_wr_n, stall_in_n, wdata_buffered, bus_request_in_n;
   logic        bus_grant_n, bus_request_out_n, release_pins_are_port;
   logic        req_out_pin_is_port, stall_pin_is_port;
   logic [2:0]  acc_area = 3'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   int          err_total = 0, checks = 0, n0, n, wb = 0, t;
   always #2 core_clk = ~core_clk;
   ebc_ctrl dut (.*);
   ebc_far_model far (.*);
   task automatic complete_run;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // One idle edge after each transfer keeps psel from toggling in a step.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      do @(posedge core_clk); while (pready !== 1'h1);
      rd = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [15:0] v);
      apb(1'h1, 12'h000, {16'h0000, v});
   endtask
   task automatic acc(input logic [3:0] p, input logic last);
      n = 0;
      acc_req <= 1'h1;
      {acc_wr, acc_area} <= p;
      do begin
         @(posedge core_clk);
         n++;
         wb += int'(wdata_buffered);
      end while (acc_ack !== 1'h1 && n < 50);
      if (last)
         acc_req <= 1'h0;
   endtask
   // The second of two back-to-back accesses grows by the idle gap.
   task automatic gap(input logic [15:0] r, input logic [7:0] p, input int g);
      wr(r);
      acc(p[7:4], 1'h0);
      acc(p[3:0], 1'h1);
      @(posedge core_clk);
      if (g < 0)
         n0 = n;
      else
         `CHK("gap", n0 + g, n)
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'h0;
      apb(1'h0, 12'h000, 32'h0);
      `CHK("reset", 32'h00001C00, rd)
      `CHK("pin role", 1'h1, req_out_pin_is_port)
      wr(16'hDF04);
      apb(1'h1, 12'h004, 32'h0);
      `CHK("slverr", 1'h1, e)
      apb(1'h0, 12'h000, 32'h0);
      `CHK("ones", 32'h0000DF04, rd)
      `CHK("stall role", 1'h0, stall_pin_is_port)
      apb(1'h0, 12'h004, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      $display("register test done");
      gap(16'h0000, 8'h08, -1);
      gap(16'h0400, 8'h08, 1);
      gap(16'h1400, 8'h08, 2);
      gap(16'h0800, 8'h12, 1);
      gap(16'h1800, 8'h11, 0);
      gap(16'h0004, 8'h80, 1);
      gap(16'h1C00, 8'h80, 0);
      `CHK("no buffer", 0, wb)
      gap(16'h0200, 8'h88, 0);
      `CHK("buffer", 2, wb)
      stall_on <= 1'h1;
      gap(16'h0100, 8'h00, 2);
      gap(16'h0000, 8'h00, 0);
      $display("cycle test done");
      want_bus <= 1'h1;
      repeat (6) @(posedge core_clk);
      `CHK("no grant", 1'h1, bus_grant_n)
      wr(16'hC000);
      for (t = 0; t < 9 && bus_grant_n !== 1'h0; t++) @(posedge core_clk);
      `CHK("grant", 1'h0, bus_grant_n)
      refresh_req <= 1'h1;
      repeat (3) @(posedge core_clk);
      `CHK("req out", 1'h0, bus_request_out_n)
      wr(16'h8000);
      repeat (2) @(posedge core_clk);
      `CHK("req out off", 1'h1, bus_request_out_n)
      $display("release test done");
      complete_run;
   end
   initial begin
      #20000;
      err_total++;
      complete_run;
   end
endmodule
